// File: hdl/led_i2c_cfg.svh
`ifndef LED_I2C_CFG_SVH
`define LED_I2C_CFG_SVH

// ****************************************************************
// Bus addressing and byte length
// ****************************************************************
`define ADDR_BASE       7'h1b
`define ADDR_ALT        7'h1a
`define BYTE_BITS       4'h8

// ****************************************************************
// Sub-address map
// ****************************************************************
`define SUB_CMD         4'h0
`define SUB_UNIVERSAL_LED_OUTPUT_FIRST  4'h1
`define SUB_UNIVERSAL_LED_OUTPUT_LAST   4'hc
`define SUB_CAM         4'hd
`define SUB_GATE_LO     4'he
`define SUB_GATE_HI     4'hf
`define NUM_REGS        16
`define NUM_UNIVERSAL_LED_OUTPUT        12

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CMD_QUICK_BIT   1
`define GATE_HI_LSB     0
`define GATE_HI_MSB     3
`define TIMING_LSB      4
`define TIMING_MSB      7
`define REG_RST         8'h00

// ****************************************************************
// Timing and buffer depth
// ****************************************************************
`define CLK_NS          8
`define FILT_NS         24
`define FILT_CYC        ((`FILT_NS + `CLK_NS - 1) / `CLK_NS)
`define FIFO_DEPTH      2

`endif

// File: hdl/led_i2c_pkg.sv
package led_i2c_pkg;

  // One byte of the register file.
  typedef logic [7:0] reg_byte_t;

  // Protocol position of the serial receiver.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SUB,
    ST_DATA,
    ST_IGNORE
  } bus_state_t;

  // A sub-address and data pair on its way to the holding latches.
  typedef struct packed {
    logic [3:0] sub;
    reg_byte_t  data;
  } reg_write_t;

endpackage

// File: hdl/line_filter.sv
`timescale 1ns/10ps
`include "led_i2c_cfg.svh"

// ****************************************************************
// Two-flop synchroniser followed by a stability filter
// ****************************************************************
module line_filter #(
  parameter int STABLE_CYC = `FILT_CYC
) (
  input  logic clk_i,
  input  logic resetn_i,
  input  logic ce_i,
  input  logic line_i,
  output logic clean_o
);

  localparam int CW = $clog2(STABLE_CYC + 1);

  logic          meta_r;
  logic          sync_r;
  logic          clean_r;
  logic [CW-1:0] cnt_r;

  // The clean level only follows the line after it has held its new
  // value for STABLE_CYC cycles, so a short spike never gets through.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_r  <= 1'b1;
      sync_r  <= 1'b1;
      clean_r <= 1'b1;
      cnt_r   <= '0;
    end else if (ce_i) begin
      meta_r <= line_i;
      sync_r <= meta_r;
      if (sync_r == clean_r) begin
        cnt_r <= '0;
      end else if (cnt_r == CW'(STABLE_CYC - 1)) begin
        clean_r <= sync_r; // see [RQ17]
        cnt_r   <= '0;
      end else begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end

  assign clean_o = clean_r;

endmodule

// File: hdl/led_i2c_write_slave.sv
// Summary of operation
// [RQ1] Bus keeps both lines high when idle through outside pull-ups.
// [RQ2] Device only receives; it pulls data low for acknowledges only.
// [RQ3] One fixed 7-bit address, base or alternate variant.
// [RQ4] Address acknowledged only with write bit zero; otherwise silent.
// [RQ5] Master sends eight bits MSB first plus an acknowledge clock.
// [RQ6] Master clocks the ninth bit and releases the data line.
// [RQ7] Device holds data low across the whole acknowledge clock.
// [RQ8] START is data falling with clock high; STOP is data rising.
// [RQ9] Master sends sub-address then data, repeated per register.
// [RQ10] Register selection uses only the low four sub-address bits.
// [RQ11] Each acknowledged data byte goes into its holding latch.
// [RQ12] Latched data survives foreign repeated STARTs; STOP applies it.
// [RQ13] STOP in the middle of a data set is discarded.
// [RQ14] Complete unapplied data is applied on any later STOP.
// [RQ15] After readdressing, no STOP acts until the new set completes.
// [RQ16] Serial port works at bus clocks up to 400kHz.
// [RQ17] Serial inputs are filtered against short glitches.
// [RQ18] Command bit 1 makes a write to level one fill all twelve.
// [RQ19] Sub-addresses 1 to 12 select the universal level registers.
// [RQ20] Sub-address 13 selects the camera high/low level register.
// [RQ21] Sub-address 14 bits route outputs to the external gate pin.
// [RQ22] Sub-address 15 holds four gate selects and timing bits.
// [RQ23] Data sampled on rising clock, bit 7 first, bit 0 last.
// [RQ24] Serial logic is static and tolerates any slow bus clock.
// [RQ25] Master changes data only while the clock is low.
`timescale 1ns/10ps
`include "led_i2c_cfg.svh"

module led_i2c_write_slave
  import led_i2c_pkg::*;
#(
  parameter bit ALT_VARIANT = 1'b0,
  parameter int FILT_CYC    = `FILT_CYC,
  parameter int FIFO_DEPTH  = `FIFO_DEPTH
) (
  input  logic                          clk_i,
  input  logic                          resetn_i,
  input  logic                          ce_i,
  input  logic                          scl_i,
  input  logic                          sda_i,
  output logic                          sda_o,
  output logic                          sda_oe_o,
  output logic [`NUM_UNIVERSAL_LED_OUTPUT-1:0][7:0]     universal_led_output_level_o,
  output logic [7:0]                    camera_level_o,
  output logic [`NUM_UNIVERSAL_LED_OUTPUT-1:0]          gate_select_o,
  output logic [3:0]                    gate_timing_o,
  output logic [7:0]                    command_o,
  output logic                          load_pulse_o
);

  // ****************************************************************
  // Constants
  // ****************************************************************
  // The pointer arithmetic below assumes a power-of-two depth.
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam logic [PW:0] FIFO_FULL = (PW+1)'(FIFO_DEPTH);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                         scl_f_w;
  logic                         sda_f_w;
  logic                         scl_d_r;
  logic                         sda_d_r;
  logic                         scl_rise_w;
  logic                         scl_fall_w;
  logic                         start_w;
  logic                         stop_w;
  logic                         decide_w;
  logic                         addr_ok_w;
  logic [6:0]                   own_addr_w;

  bus_state_t                   state_r;
  bus_state_t                   state_nxt;
  logic [3:0]                   cnt_r;
  logic [3:0]                   cnt_nxt;
  logic [7:0]                   shift_r;
  logic [7:0]                   shift_nxt;
  logic                         ack_ph_r;
  logic                         ack_ph_nxt;
  logic                         oe_r;
  logic                         oe_nxt;
  logic                         busy_r;
  logic                         busy_nxt;
  logic [3:0]                   sub_r;
  logic [3:0]                   sub_nxt;
  logic                         apply_r;
  logic                         apply_nxt;
  logic                         pend_r;
  logic                         pend_nxt;
  logic                         load_r;
  logic                         sda_low_r;
  logic                         apply_fire_w;

  reg_write_t                   fifo_mem_r [FIFO_DEPTH];
  logic [PW-1:0]                fifo_wp_r;
  logic [PW-1:0]                fifo_rp_r;
  logic [PW:0]                  fifo_cnt_r;
  reg_write_t                   push_data_w;
  reg_write_t                   pop_data_w;
  logic                         push_ready_w;
  logic                         push_w;
  logic                         pop_valid_w;
  logic                         pop_ready_w;
  logic                         pop_w;
  logic                         quick_w;

  logic [`NUM_REGS-1:0][7:0]    hold_r;
  logic [`NUM_REGS-1:0][7:0]    act_r;
  logic [`NUM_REGS-1:0]         hold_we_w;

  // ****************************************************************
  // Input conditioning
  // ****************************************************************
  // Both lines are pins from outside this clock domain, so each goes
  // through a synchroniser and a glitch filter before anyone looks at it.
  line_filter #(
    .STABLE_CYC (FILT_CYC)
  ) u_scl_filter (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .line_i     (scl_i),
    .clean_o    (scl_f_w)
  );

  line_filter #(
    .STABLE_CYC (FILT_CYC)
  ) u_sda_filter (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .line_i     (sda_i),
    .clean_o    (sda_f_w)
  );

  // Previous filtered levels for edge detection.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (ce_i) begin
      scl_d_r <= scl_f_w;
      sda_d_r <= sda_f_w;
    end
  end

  // ****************************************************************
  // Bus event decode
  // ****************************************************************
  // The bus clock is only sampled, never used as a clock, so the port
  // has no lower speed limit and any stall is harmless.
  assign scl_rise_w = scl_f_w & ~scl_d_r;                   // see [RQ24]
  assign scl_fall_w = ~scl_f_w & scl_d_r;
  assign start_w    = scl_f_w & scl_d_r & sda_d_r & ~sda_f_w; // see [RQ8]
  assign stop_w     = scl_f_w & scl_d_r & ~sda_d_r & sda_f_w; // see [RQ8]
  assign decide_w   = scl_fall_w & ~ack_ph_r & (cnt_r == `BYTE_BITS);
  assign own_addr_w = ALT_VARIANT ? `ADDR_ALT : `ADDR_BASE;   // see [RQ3]
  // A read request to our address is treated like a foreign address.
  assign addr_ok_w  = (shift_r[7:1] == own_addr_w) & ~shift_r[0]; // see [RQ4]

  // ****************************************************************
  // Receiver state machine
  // ****************************************************************
  // One pass per bus event; START and STOP override bit handling since
  // they may cut a byte short at any point.
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    shift_nxt  = shift_r;
    ack_ph_nxt = ack_ph_r;
    oe_nxt     = oe_r;
    busy_nxt   = busy_r;
    sub_nxt    = sub_r;
    apply_nxt  = apply_r & ~apply_fire_w;
    if (start_w) begin
      // Repeated START to another chip leaves the latches alone.
      state_nxt  = ST_ADDR;                                  // see [RQ12]
      cnt_nxt    = '0;
      ack_ph_nxt = 1'b0;
      oe_nxt     = 1'b0;
    end else if (stop_w) begin
      state_nxt  = ST_IDLE;
      cnt_nxt    = '0;
      ack_ph_nxt = 1'b0;
      oe_nxt     = 1'b0;
      // A STOP inside an unfinished set is dropped; otherwise any STOP
      // applies complete data, however many STARTs came between.
      if (!busy_r && pend_r) begin                           // see [RQ13]
        apply_nxt = 1'b1;                                    // see [RQ14]
      end
    end else if (scl_rise_w && !ack_ph_r && cnt_r != `BYTE_BITS) begin
      shift_nxt = {shift_r[6:0], sda_f_w};                   // see [RQ23]
      cnt_nxt   = cnt_r + 4'h1;
    end else if (scl_fall_w && ack_ph_r) begin
      // Release only after the ninth clock falls, so the low level
      // covers the whole high phase of that clock.
      ack_ph_nxt = 1'b0;                                     // see [RQ7]
      oe_nxt     = 1'b0;
      cnt_nxt    = '0;
    end else if (decide_w) begin
      ack_ph_nxt = 1'b1;
      unique case (state_r)
        ST_ADDR: begin
          if (addr_ok_w) begin
            oe_nxt    = 1'b1;                                // see [RQ7]
            busy_nxt  = 1'b1;                                // see [RQ15]
            state_nxt = ST_SUB;
          end else begin
            state_nxt = ST_IGNORE;
          end
        end
        ST_SUB: begin
          oe_nxt    = 1'b1;
          sub_nxt   = shift_r[3:0];                          // see [RQ10]
          state_nxt = ST_DATA;
        end
        ST_DATA: begin
          // A full buffer refuses the byte rather than losing it.
          if (push_ready_w) begin
            oe_nxt    = 1'b1;                                // see [RQ11]
            busy_nxt  = 1'b0;
            state_nxt = ST_SUB;
          end else begin
            state_nxt = ST_IGNORE;
          end
        end
        ST_IDLE: begin
          state_nxt = ST_IDLE;
        end
        ST_IGNORE: begin
          state_nxt = ST_IGNORE;
        end
      endcase
    end
  end

  // Pending data is set by a new complete pair; set wins over apply.
  assign pend_nxt = push_w | (pend_r & ~apply_fire_w);

  // State registers of the receiver.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_r  <= ST_IDLE;
      cnt_r    <= '0;
      shift_r  <= '0;
      ack_ph_r <= 1'b0;
      oe_r     <= 1'b0;
      busy_r   <= 1'b0;
      sub_r    <= '0;
      apply_r  <= 1'b0;
      pend_r   <= 1'b0;
    end else if (ce_i) begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      shift_r  <= shift_nxt;
      ack_ph_r <= ack_ph_nxt;
      oe_r     <= oe_nxt;
      busy_r   <= busy_nxt;
      sub_r    <= sub_nxt;
      apply_r  <= apply_nxt;
      pend_r   <= pend_nxt;
    end
  end

  // ****************************************************************
  // Write buffer
  // ****************************************************************
  // Pairs are pushed at the acknowledge and drained into the latches.
  // The drain stalls for the load cycle so a late write is not mixed
  // into the copy that is being applied.
  assign push_data_w  = '{sub: sub_r, data: shift_r};
  assign push_ready_w = (fifo_cnt_r != FIFO_FULL);
  assign push_w       = decide_w & (state_r == ST_DATA) & push_ready_w;
  assign pop_valid_w  = (fifo_cnt_r != '0);
  assign pop_ready_w  = ~load_r;
  assign pop_w        = pop_valid_w & pop_ready_w;
  assign pop_data_w   = fifo_mem_r[fifo_rp_r];

  // Pointer and occupancy update.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      fifo_wp_r  <= '0;
      fifo_rp_r  <= '0;
      fifo_cnt_r <= '0;
    end else if (ce_i) begin
      if (push_w) begin
        fifo_wp_r <= fifo_wp_r + PW'(1);
      end
      if (pop_w) begin
        fifo_rp_r <= fifo_rp_r + PW'(1);
      end
      if (push_w && !pop_w) begin
        fifo_cnt_r <= fifo_cnt_r + (PW+1)'(1);
      end else if (pop_w && !push_w) begin
        fifo_cnt_r <= fifo_cnt_r - (PW+1)'(1);
      end
    end
  end

  // Storage needs no reset; an entry is read only once written.
  always_ff @(posedge clk_i) begin
    if (ce_i && push_w) begin
      fifo_mem_r[fifo_wp_r] <= push_data_w;
    end
  end

  // ****************************************************************
  // Holding latches and active registers
  // ****************************************************************
  // Quick write looks at the latched command, so it takes effect for
  // the pair right after the command pair, before any STOP.
  assign quick_w = hold_r[`SUB_CMD][`CMD_QUICK_BIT]
                 & (pop_data_w.sub == `SUB_UNIVERSAL_LED_OUTPUT_FIRST);      // see [RQ18]

  // Write enables: 0 command, 1..12 levels, 13 camera, 14/15 gate.
  for (genvar i = 0; i < `NUM_REGS; i++) begin : g_we
    localparam logic [3:0] IDX = 4'(i);
    localparam bit IS_UNIVERSAL_LED_OUTPUT = (IDX >= `SUB_UNIVERSAL_LED_OUTPUT_FIRST)
                           && (IDX <= `SUB_UNIVERSAL_LED_OUTPUT_LAST);       // see [RQ19]
    assign hold_we_w[i] = pop_w
                        & ((pop_data_w.sub == IDX) | (quick_w & IS_UNIVERSAL_LED_OUTPUT));
  end

  // Data only reaches the active registers when the buffer is empty and
  // a qualifying STOP has been seen.
  assign apply_fire_w = apply_r & ~pop_valid_w;              // see [RQ12]

  // Holding latches, active copy and the load pulse.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      hold_r <= {`NUM_REGS{`REG_RST}};
      act_r  <= {`NUM_REGS{`REG_RST}};
      load_r <= 1'b0;
    end else if (ce_i) begin
      for (int i = 0; i < `NUM_REGS; i++) begin
        if (hold_we_w[i]) begin
          hold_r[i] <= pop_data_w.data;                      // see [RQ11]
        end
      end
      if (apply_fire_w) begin
        act_r <= hold_r;                                     // see [RQ14]
      end
      load_r <= apply_fire_w;
    end
  end

  // The data pin is only ever pulled low, never driven high.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sda_low_r <= 1'b0;
    end else if (ce_i) begin
      sda_low_r <= 1'b0;                                     // see [RQ2]
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sda_o          = sda_low_r;
  assign sda_oe_o       = oe_r;                               // see [RQ2]
  assign universal_led_output_level_o   = act_r[`SUB_UNIVERSAL_LED_OUTPUT_LAST:`SUB_UNIVERSAL_LED_OUTPUT_FIRST]; // see [RQ19]
  assign camera_level_o = act_r[`SUB_CAM];                    // see [RQ20]
  assign gate_select_o  = {act_r[`SUB_GATE_HI][`GATE_HI_MSB:`GATE_HI_LSB],
                           act_r[`SUB_GATE_LO]};              // see [RQ21]
  assign gate_timing_o  = act_r[`SUB_GATE_HI][`TIMING_MSB:`TIMING_LSB]; // see [RQ22]
  assign command_o      = act_r[`SUB_CMD];
  assign load_pulse_o   = load_r;

endmodule

// File: tb/host_master_model.sv
`timescale 1ns/10ps

// ****************************************************************
// Host master on the two-wire bus
// ****************************************************************
module host_master_model (
  input  logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // A quarter of the 125 ns bus clock period.
  localparam realtime QTR = 31.25;
  logic glitch_r;

  // Both lines released at start, so the pull-ups hold them high.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    glitch_r = 1'b0;
  end

  // Serves as a first or a repeated START.
  task automatic start_cond();
    #QTR sda_o = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR sda_o = 1'b0;
    #QTR scl_o = 1'b0;
  endtask

  // The tail leaves the bus idle long enough for the next START.
  task automatic stop_cond();
    #QTR sda_o = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR sda_o = 1'b1;
    #(4*QTR);
  endtask

  // A glitch pulse, when enabled, is far shorter than the filter span.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #QTR sda_o = b[i];
      #QTR scl_o = 1'b1;
      #(2*QTR) scl_o = 1'b0;
      if (glitch_r && i == 4) begin
        #10 scl_o = 1'b1;
        #10 scl_o = 1'b0;
      end
    end
    #QTR sda_o = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR ack = ~sda_i;
    #QTR scl_o = 1'b0;
  endtask
endmodule

// File: tb/led_i2c_write_slave_assertions.sv
`timescale 1ns/10ps
`include "led_i2c_cfg.svh"

// ****************************************************************
// Port checker for the serial write slave
// ****************************************************************
module led_i2c_checker #(
  parameter int FILT_CYC = 3
) (
  input logic                      clk_i,
  input logic                      resetn_i,
  input logic                      scl_i,
  input logic                      sda_i,
  input logic                      sda_o,
  input logic                      sda_oe_o,
  input logic [`NUM_UNIVERSAL_LED_OUTPUT-1:0][7:0] universal_led_output_level_o,
  input logic [7:0]                camera_level_o,
  input logic [`NUM_UNIVERSAL_LED_OUTPUT-1:0]      gate_select_o,
  input logic [3:0]                gate_timing_o,
  input logic [7:0]                command_o,
  input logic                      load_pulse_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  logic       scl_d_r, sda_d_r;
  logic [4:0] fall_age_r, stop_age_r, idle_age_r;
  logic [4:0] fall_age_nxt, stop_age_nxt, idle_age_nxt;
  logic [127:0] regs_w;

  function automatic logic [4:0] sat(input logic [4:0] v);
    return (v == 5'h1f) ? v : v + 5'h01;
  endfunction

  // Ages since the last pin clock fall, pin STOP and start of idle.
  // Counting at the pins keeps the filter delay out of the helper.
  assign fall_age_nxt = (scl_d_r & ~scl_i) ? 5'h00 : sat(fall_age_r);
  assign stop_age_nxt = (scl_i & sda_i & ~sda_d_r) ? 5'h00
                                                   : sat(stop_age_r);
  assign idle_age_nxt = (scl_i & sda_i) ? sat(idle_age_r) : 5'h00;
  assign regs_w = {universal_led_output_level_o, camera_level_o, gate_select_o,
                   gate_timing_o, command_o};

  // Helper registers.
  always_ff @(posedge clk_i) begin
    scl_d_r <= resetn_i ? scl_i : 1'b1;
    sda_d_r <= resetn_i ? sda_i : 1'b1;
    fall_age_r <= resetn_i ? fall_age_nxt : 5'h1f;
    stop_age_r <= resetn_i ? stop_age_nxt : 5'h1f;
    idle_age_r <= resetn_i ? idle_age_nxt : 5'h00;
  end

  chk_ack_drives_low:
    assert property (sda_oe_o |-> !sda_o) else $error("ack not low");
  chk_ack_holds_high:
    assert property (sda_oe_o && scl_i |=> sda_oe_o)
      else $error("ack dropped in clock high");
  chk_ack_length:
    assert property ($rose(sda_oe_o) |-> sda_oe_o[*8] ##[1:20] !sda_oe_o)
      else $error("ack length wrong");
  chk_ack_after_fall:
    assert property ($rose(sda_oe_o) |-> fall_age_r <= FILT_CYC + 8)
      else $error("ack not after clock fall");
  chk_idle_silent:
    assert property (idle_age_r == 5'h1f |-> !sda_oe_o)
      else $error("ack on idle bus");
  chk_regs_hold:
    assert property (!load_pulse_o |-> $stable(regs_w))
      else $error("register moved without load");
  chk_load_single:
    assert property (load_pulse_o |=> !load_pulse_o)
      else $error("load pulse too long");
  chk_load_on_stop:
    assert property (load_pulse_o |-> stop_age_r <= 5'd16)
      else $error("load without stop");
  chk_load_not_ack:
    assert property (load_pulse_o |-> !sda_oe_o)
      else $error("load during ack");

  cover property ($rose(load_pulse_o));
  cover property ($rose(sda_oe_o));
  cover property (load_pulse_o && universal_led_output_level_o[11] != 8'h00);
endmodule

bind led_i2c_write_slave led_i2c_checker #(.FILT_CYC(FILT_CYC)) chk_u (
  .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .universal_led_output_level_o(universal_led_output_level_o),
  .camera_level_o(camera_level_o), .gate_select_o(gate_select_o),
  .gate_timing_o(gate_timing_o), .command_o(command_o),
  .load_pulse_o(load_pulse_o));

// File: tb/tb_top.sv
`timescale 1ns/10ps
`include "led_i2c_cfg.svh"

// ****************************************************************
// Testbench top
// ****************************************************************
module tb_top import led_i2c_pkg::*;;
  logic                      clk_i, resetn_i, scl_w, m_sda_w, sda_w;
  logic                      sda_o, sda_oe_o, load_pulse_o;
  logic [`NUM_UNIVERSAL_LED_OUTPUT-1:0][7:0] universal_led_output_level_o;
  logic [7:0]                camera_level_o, command_o;
  logic [`NUM_UNIVERSAL_LED_OUTPUT-1:0]      gate_select_o;
  logic [3:0]                gate_timing_o;
  reg_byte_t                 pend [16];
  reg_byte_t                 act [16];
  int                        err_count, tests_run, loads;

  // Open-drain data wire: anyone pulling low wins over the pull-up.
  assign sda_w = m_sda_w & ~(sda_oe_o & ~sda_o);

  led_i2c_write_slave dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .scl_i(scl_w),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .universal_led_output_level_o(universal_led_output_level_o), .camera_level_o(camera_level_o),
    .gate_select_o(gate_select_o), .gate_timing_o(gate_timing_o),
    .command_o(command_o), .load_pulse_o(load_pulse_o));

  host_master_model mst_u (.sda_i(sda_w), .scl_o(scl_w), .sda_o(m_sda_w));

  // Clock, and load pulses counted on the falling edge once settled.
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(negedge clk_i) if (load_pulse_o === 1'b1) loads++;

  task automatic conclude();
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send(input reg_byte_t b, input logic e);
    logic a;
    mst_u.send_byte(b, a);
    check({11'h0, a}, {11'h0, e});
  endtask

  task automatic open_dev();
    mst_u.start_cond();
    send({`ADDR_BASE, 1'b0}, 1'b1);
  endtask

  // The upper sub-address nibble is junk that must be ignored.
  task automatic wr(input logic [3:0] sub, input reg_byte_t d);
    send({4'ha, sub}, 1'b1);
    send(d, 1'b1);
    pend[sub] = d;
    if (sub == `SUB_UNIVERSAL_LED_OUTPUT_FIRST && pend[0][`CMD_QUICK_BIT])
      for (int k = 2; k <= `NUM_UNIVERSAL_LED_OUTPUT; k++) pend[k] = d;
  endtask

  // A STOP, then a bounded wait for the load pulse.
  task automatic close(input logic e);
    int n0;
    n0 = loads;
    mst_u.stop_cond();
    for (int k = 0; k < 40 && loads == n0; k++) @(posedge clk_i);
    check(12'(loads - n0), {11'h0, e});
    if (e && loads == n0) conclude();
    if (e) act = pend;
  endtask

  task automatic check_regs();
    for (int k = 0; k < `NUM_UNIVERSAL_LED_OUTPUT; k++)
      check({4'h0, universal_led_output_level_o[k]}, {4'h0, act[k+1]});
    check({4'h0, camera_level_o}, {4'h0, act[13]});
    check(gate_select_o, {act[15][3:0], act[14]});
    check({8'h0, gate_timing_o}, {8'h0, act[15][7:4]});
    check({4'h0, command_o}, {4'h0, act[0]});
  endtask

  // Main sequence.
  initial begin
    resetn_i = 1'b0;
    err_count = 0;
    tests_run = 0;
    loads = 0;
    for (int k = 0; k < 16; k++) begin
      pend[k] = 8'h00;
      act[k] = 8'h00;
    end
    repeat (4) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    repeat (20) @(posedge clk_i);
    check_regs();
    // Whole map in one set; nothing moves before the STOP.
    open_dev();
    for (int k = 0; k < 16; k++) wr(4'(k), {~4'(k), 4'(k)});
    check_regs();
    close(1'b1);
    check_regs();
    // Read bit set, then a foreign address: both stay silent.
    mst_u.start_cond();
    send({`ADDR_BASE, 1'b1}, 1'b0);
    send(8'h31, 1'b0);
    mst_u.start_cond();
    send({`ADDR_ALT, 1'b0}, 1'b0);
    close(1'b0);
    // A complete set survives a foreign repeated START.
    open_dev();
    wr(4'h5, 8'h2a);
    mst_u.start_cond();
    send({`ADDR_ALT, 1'b0}, 1'b0);
    check_regs();
    close(1'b1);
    check_regs();
    // Readdressing leaves a set incomplete, so its STOP is discarded.
    open_dev();
    wr(4'h6, 8'h15);
    open_dev();
    send(8'h07, 1'b1);
    close(1'b0);
    open_dev();
    wr(4'h8, 8'h07);
    close(1'b1);
    check_regs();
    // Quick write fills all level registers, then is switched off.
    open_dev();
    wr(4'h0, 8'h02);
    wr(4'h1, 8'h3c);
    close(1'b1);
    check_regs();
    open_dev();
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h11);
    close(1'b1);
    check_regs();
    // A clock glitch in mid-byte must not add a bit.
    mst_u.glitch_r = 1'b1;
    open_dev();
    wr(4'h9, 8'h96);
    mst_u.glitch_r = 1'b0;
    close(1'b1);
    check_regs();
    conclude();
  end
endmodule
